// [verilog/ibsc_pkg.sv]
// Shared constants and types for the isolation barrier sync controller.
// Assumes a single 200 MHz clock and Avalon-MM register access.
package ibsc_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ         = 200;
  localparam int NTR_TIME_US     = 400;
  localparam int NTR_CYCLES      = NTR_TIME_US * CLK_MHZ;
  localparam int SER_HALF_CYCLES = 4;
  localparam int RX_BIT_CYCLES   = 8;
  localparam int FRAME_BITS      = 10;
  localparam logic [1:0] SER_HALF_LAST = 2'(SER_HALF_CYCLES - 1);
  localparam logic [3:0] FRAME_LAST    = 4'(FRAME_BITS - 1);
  localparam logic [3:0] RX_FIRST      =
    4'(RX_BIT_CYCLES + RX_BIT_CYCLES / 2 - 1);
  localparam logic [3:0] RX_NEXT       = 4'(RX_BIT_CYCLES - 1);

  // ************************************************************
  // Register indices, byte address is index times four
  // ************************************************************
  localparam logic [5:0] IDX_POWER     = 6'h02;
  localparam logic [5:0] IDX_IRQ_STAT  = 6'h03;
  localparam logic [5:0] IDX_ENABLE    = 6'h05;
  localparam logic [5:0] IDX_HOST_STAT = 6'h0d;
  localparam logic [5:0] IDX_FAILSAFE  = 6'h15;
  localparam logic [5:0] IDX_REVISION  = 6'h1d;
  localparam logic [5:0] IDX_LINE_STAT = 6'h1e;
  localparam logic [5:0] IDX_AUX_ADC   = 6'h20;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int LPS_BIT    = 2;
  localparam int LDE_BIT    = 3;
  localparam int MODE_BIT   = 7;
  localparam int SYNC_LOSS_IRQ_FLAG_BIT   = 1;
  localparam int POLL_BIT   = 3;
  localparam int SYNLEN_BIT = 1;
  localparam int HOST_SIDE_SYNC_LOST_BIT   = 6;
  localparam int NTR_BIT    = 6;
  localparam int REV_LSB    = 4;
  localparam int LINE_SIDE_SYNC_LOST_BIT   = 2;
  localparam logic SYNC_LOSS_IRQ_FLAG_EN_RST   = 1'b1;
  localparam logic AUTO_POLL_RST = 1'b1;
  localparam logic HOST_SIDE_SYNC_LOST_RST      = 1'b1;

  // ************************************************************
  // Link symbols
  // ************************************************************
  localparam logic [7:0] PREAMBLE_BYTE = 8'haa;
  localparam logic [7:0] STATUS_BYTE   = 8'h5a;
  localparam logic [7:0] POLL_BYTE     = 8'hc3;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    S_XFER1E, S_PREAMBLE, S_RX_SYNC, S_POLL, S_WAIT_REV, S_RUN
  } ibsc_link_e;
  typedef enum logic [1:0] {R_IDLE, R_DATA, R_STOP} ibsc_rx_e;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } ibsc_avs_req_s;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } ibsc_avs_rsp_s;

  typedef struct packed {
    ibsc_link_e  link;
    ibsc_rx_e    rxs;
    logic [2:0]  rx_sync;
    logic        rx_lvl;
    logic [3:0]  rx_cnt;
    logic [2:0]  rx_bits;
    logic [7:0]  rx_sh;
    logic [7:0]  rx_word;
    logic        rx_valid;
    logic [16:0] ntr_cnt;
    logic        trip;
    logic        ack;
    logic [7:0]  rdata;
    logic        lps;
    logic        lde;
    logic        line_mode;
    logic        sync_loss_irq_flag;
    logic        sync_loss_irq_flag_en;
    logic        auto_poll;
    logic        host_side_sync_lost;
    logic        ntr_off;
    logic [3:0]  rev;
    logic        line_side_sync_lost;
    logic [7:0]  aux;
  } ibsc_ctl_s;

  localparam ibsc_ctl_s CTL_RST = '{link: S_PREAMBLE, rxs: R_IDLE,
    sync_loss_irq_flag_en: SYNC_LOSS_IRQ_FLAG_EN_RST, auto_poll: AUTO_POLL_RST, host_side_sync_lost: HOST_SIDE_SYNC_LOST_RST,
    default: '0};

  function automatic logic is_sync(input ibsc_link_e s);
    return s inside {S_RX_SYNC, S_POLL, S_WAIT_REV, S_RUN};
  endfunction : is_sync

endpackage : ibsc_pkg

// [verilog/ibsc_ser.sv]
// Barrier transmit serializer with interleaved power pulses.
// Assumes the caller always offers a byte; one is taken when idle.
`timescale 1ns/100ps
`default_nettype none
module ibsc_ser
  import ibsc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic [7:0] data,
  input  wire logic       power_on,
  output logic            take,
  output logic            tx
);

  typedef struct packed {
    logic       busy;
    logic       power;
    logic [9:0] frame;
    logic [3:0] bits;
    logic       phase;
    logic [1:0] cnt;
    logic       tx;
  } ibsc_ser_s;

  ibsc_ser_s r;
  ibsc_ser_s n;

  // ************************************************************
  // Slot sequencing
  // ************************************************************
  // Each bit slot: first half power pulse, second half data
  always_comb begin
    n    = r;
    take = ~r.busy;
    if (!r.busy) begin
      n.busy  = 1'b1;
      n.frame = {1'b1, data, 1'b0};
      n.bits  = '0;
      n.phase = 1'b0;
      n.cnt   = '0;
      n.power = power_on;
    end else if (r.cnt == SER_HALF_LAST) begin
      n.cnt   = '0;
      n.phase = ~r.phase;
      if (r.phase) begin
        if (r.bits == FRAME_LAST) begin
          n.busy = 1'b0;
        end else begin
          n.bits  = r.bits + 4'd1;
          n.frame = {r.frame[8:0], 1'b0};
        end
      end
    end else begin
      n.cnt = r.cnt + 2'd1;
    end
    n.tx = n.busy & (n.phase ? n.frame[9] : n.power);
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tx = r.tx;

endmodule : ibsc_ser
`default_nettype wire

// [verilog/ibsc_top.sv]
// Host-side barrier synchronization and control with register slave.
// Assumes the line side answers preamble with a status byte, then a
// revision byte after a poll; barrier_rx is asynchronous.
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module ibsc_top
  import ibsc_pkg::*;
#(
  parameter int NTR_LIMIT = NTR_CYCLES
) (
  input  wire logic          clock,
  input  wire logic          arst_n,
  input  wire ibsc_avs_req_s avs_req,
  output var  ibsc_avs_rsp_s avs_rsp,
  output logic               irq,
  output logic               barrier_tx,
  input  wire logic          barrier_rx,
  input  wire logic [7:0]    tx_word,
  output logic               tx_ready_strobe,
  output logic [7:0]         rx_word,
  output logic               rx_valid,
  output logic               failsafe_trip,
  output logic               line_power_mode,
  input  wire logic [7:0]    aux_adc_pos_input,
  input  wire logic [7:0]    aux_adc_neg_input
);

  ibsc_ctl_s  r;
  ibsc_ctl_s  n;
  logic       req;
  logic       bus_acc;
  logic [5:0] idx;
  logic [7:0] wdat;
  logic [7:0] rd;
  logic       rx_edge;
  logic       byte_done;
  logic       frame_err;
  logic [7:0] rx_byte;
  logic       trip_now;
  logic       loss_evt;
  logic [7:0] ser_byte;
  logic       ser_take;

  function automatic logic hit(input logic acc,
                               input logic [5:0] a,
                               input logic [5:0] i);
    return acc & (a == i);
  endfunction : hit

  ibsc_ser u_ser (
    .clock    (clock),
    .arst_n   (arst_n),
    .data     (ser_byte),
    .power_on (~r.line_mode),
    .take     (ser_take),
    .tx       (barrier_tx)
  );

  always_comb begin
    n          = r;
    n.rx_valid = 1'b0;
    rd         = '0;
    byte_done  = 1'b0;
    frame_err  = 1'b0;
    rx_byte    = r.rx_sh;
    trip_now   = 1'b0;
    loss_evt   = 1'b0;
    ser_byte   = PREAMBLE_BYTE;

    // ************************************************************
    // Avalon slave: one wait cycle, then accept
    // ************************************************************
    req     = avs_req.read | avs_req.write;
    bus_acc = req & r.ack;
    idx     = avs_req.address[7:2];
    wdat    = avs_req.writedata[7:0] & {8{avs_req.byteenable[0]}};
    n.ack   = req & ~r.ack;
    case (idx)
      IDX_POWER: begin
        rd[LPS_BIT]  = r.lps;
        rd[LDE_BIT]  = r.lde;
        rd[MODE_BIT] = r.line_mode;
      end
      IDX_IRQ_STAT:  rd[SYNC_LOSS_IRQ_FLAG_BIT] = r.sync_loss_irq_flag;
      IDX_ENABLE: begin
        rd[POLL_BIT]   = r.auto_poll;
        rd[SYNLEN_BIT] = r.sync_loss_irq_flag_en;
      end
      IDX_HOST_STAT: rd[HOST_SIDE_SYNC_LOST_BIT] = r.host_side_sync_lost;
      IDX_REVISION:  rd[REV_LSB +: 4] = r.rev;
      IDX_LINE_STAT: rd[LINE_SIDE_SYNC_LOST_BIT] = r.line_side_sync_lost;
      IDX_AUX_ADC:   rd = r.aux;
      default:       rd = '0;
    endcase
    // Snapshot taken in the wait cycle; clear-on-read uses it
    if (req && !r.ack) begin
      n.rdata = avs_req.read ? rd : 8'h00;
    end

    if (hit(bus_acc & avs_req.write, idx, IDX_POWER) &&
        avs_req.byteenable[0]) begin
      n.lps = wdat[LPS_BIT];
      n.lde = wdat[LDE_BIT];
    end
    if (hit(bus_acc & avs_req.write, idx, IDX_ENABLE) &&
        avs_req.byteenable[0]) begin
      n.auto_poll = wdat[POLL_BIT];
      n.sync_loss_irq_flag_en   = wdat[SYNLEN_BIT];
    end
    if (hit(bus_acc & avs_req.write, idx, IDX_FAILSAFE) &&
        avs_req.byteenable[0]) begin
      n.ntr_off = wdat[NTR_BIT];
    end
    if (hit(bus_acc & avs_req.write, idx, IDX_LINE_STAT) &&
        avs_req.byteenable[0]) begin
      n.line_side_sync_lost = wdat[LINE_SIDE_SYNC_LOST_BIT];
    end

    // ************************************************************
    // Powering mode
    // ************************************************************
    // Return to barrier power is refused while level detect is on
    if (r.lps) begin
      n.line_mode = 1'b1;
    end else if (!r.lde) begin
      n.line_mode = 1'b0;
    end else begin
      n.line_mode = r.line_mode;
    end

    // ************************************************************
    // Receive synchronizer and deframer
    // ************************************************************
    n.rx_sync = {r.rx_sync[1:0], barrier_rx};
    if (r.rx_sync[1] == r.rx_sync[2]) begin
      n.rx_lvl = r.rx_sync[2];
    end
    rx_edge = n.rx_lvl ^ r.rx_lvl;
    unique case (r.rxs)
      R_IDLE: begin
        if (rx_edge && n.rx_lvl) begin
          n.rxs     = R_DATA;
          n.rx_cnt  = RX_FIRST;
          n.rx_bits = '0;
        end
      end
      R_DATA: begin
        if (r.rx_cnt == 4'd0) begin
          n.rx_sh  = {r.rx_sh[6:0], r.rx_lvl};
          n.rx_cnt = RX_NEXT;
          if (r.rx_bits == 3'd7) begin
            n.rxs = R_STOP;
          end else begin
            n.rx_bits = r.rx_bits + 3'd1;
          end
        end else begin
          n.rx_cnt = r.rx_cnt - 4'd1;
        end
      end
      R_STOP: begin
        if (r.rx_cnt == 4'd0) begin
          byte_done = 1'b1;
          frame_err = r.rx_lvl;
          n.rxs     = R_IDLE;
        end else begin
          n.rx_cnt = r.rx_cnt - 4'd1;
        end
      end
    endcase

    // ************************************************************
    // No-transition watchdog
    // ************************************************************
    if (rx_edge || r.ntr_off) begin
      n.ntr_cnt = '0;
    end else if (r.ntr_cnt == 17'(NTR_LIMIT - 1)) begin
      trip_now  = 1'b1;
      n.ntr_cnt = '0;
    end else begin
      n.ntr_cnt = r.ntr_cnt + 17'd1;
    end
    n.trip = trip_now;

    // ************************************************************
    // Link sequencing
    // ************************************************************
    unique case (r.link)
      S_XFER1E: begin
        ser_byte = 8'(r.line_side_sync_lost) << LINE_SIDE_SYNC_LOST_BIT;
        if (ser_take) begin
          n.link = S_PREAMBLE;
        end
      end
      S_PREAMBLE: begin
        ser_byte = PREAMBLE_BYTE;
        if (byte_done && !frame_err && rx_byte == STATUS_BYTE) begin
          n.link = S_RX_SYNC;
        end
      end
      S_RX_SYNC: begin
        ser_byte = PREAMBLE_BYTE;
        n.link   = r.auto_poll ? S_POLL : S_RUN;
      end
      S_POLL: begin
        ser_byte = POLL_BYTE;
        if (ser_take) begin
          n.link = S_WAIT_REV;
        end
      end
      S_WAIT_REV: begin
        ser_byte = tx_word;
        if (byte_done && !frame_err) begin
          n.rev  = rx_byte[3:0];
          n.link = S_RUN;
        end
      end
      S_RUN: begin
        ser_byte = tx_word;
        if (byte_done && !frame_err) begin
          n.rx_word  = rx_byte;
          n.rx_valid = 1'b1;
        end
      end
    endcase

    // ************************************************************
    // Sync loss and flags; a set in the clearing cycle wins
    // ************************************************************
    loss_evt = is_sync(r.link) & (frame_err | trip_now);
    if (hit(bus_acc & avs_req.read, idx, IDX_IRQ_STAT) &&
        r.rdata[SYNC_LOSS_IRQ_FLAG_BIT]) begin
      n.sync_loss_irq_flag = 1'b0;
    end
    if (hit(bus_acc & avs_req.write, idx, IDX_IRQ_STAT) &&
        wdat[SYNC_LOSS_IRQ_FLAG_BIT]) begin
      n.sync_loss_irq_flag = 1'b0;
    end
    if (hit(bus_acc & avs_req.read, idx, IDX_HOST_STAT) &&
        r.rdata[HOST_SIDE_SYNC_LOST_BIT]) begin
      n.host_side_sync_lost = 1'b0;
    end
    if (loss_evt) begin
      n.sync_loss_irq_flag = 1'b1;
      n.host_side_sync_lost = 1'b1;
      n.rev  = 4'h0;
      n.link = r.line_side_sync_lost ? S_PREAMBLE : S_XFER1E;
    end else if (trip_now) begin
      n.host_side_sync_lost = 1'b1;
    end

    n.aux = aux_adc_pos_input - aux_adc_neg_input;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      r <= CTL_RST;
    end else begin
      r <= n;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign avs_rsp.readdata    = {24'h000000, r.rdata};
  assign avs_rsp.waitrequest = req & ~r.ack;
  assign irq                 = r.sync_loss_irq_flag & r.sync_loss_irq_flag_en;
  // Strobes keep running through a loss unless the line reported one
  assign tx_ready_strobe     = ser_take & (is_sync(r.link) | ~r.line_side_sync_lost);
  assign rx_word             = r.rx_word;
  assign rx_valid            = r.rx_valid;
  assign failsafe_trip       = r.trip;
  assign line_power_mode     = r.line_mode;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  sequence s_loss;
    loss_evt;
  endsequence

  sequence s_restarted;
    !is_sync(r.link) && r.sync_loss_irq_flag && r.host_side_sync_lost;
  endsequence

  sequence s_poll_sent;
    r.link == S_POLL ##1 (r.link == S_POLL) [*1];
  endsequence

  property p_restart;
    s_loss |=> s_restarted;
  endproperty

  AST_LOSS_RESTART: assert property (p_restart)
    else $error("sync loss did not set flags and restart");

  AST_REV_CLEARED: assert property (s_loss |=> r.rev == 4'h0)
    else $error("revision not cleared on sync loss");

  AST_REV_ONLY_SYNC: assert property (
    r.rev != 4'h0 |-> is_sync(r.link))
    else $error("revision nonzero while unsynchronized");

  AST_IRQ_LEVEL: assert property (
    irq == (r.sync_loss_irq_flag & r.sync_loss_irq_flag_en))
    else $error("interrupt level does not follow flag and enable");

  AST_SYNC_LOSS_IRQ_FLAG_RC: assert property (
    hit(bus_acc & avs_req.read, idx, IDX_IRQ_STAT) && r.rdata[SYNC_LOSS_IRQ_FLAG_BIT]
    && !loss_evt |=> !r.sync_loss_irq_flag && !irq)
    else $error("sync loss flag not cleared by read");

  AST_HOST_SIDE_SYNC_LOST_RC: assert property (
    hit(bus_acc & avs_req.read, idx, IDX_HOST_STAT) &&
    r.rdata[HOST_SIDE_SYNC_LOST_BIT] && !trip_now && !loss_evt |=> !r.host_side_sync_lost)
    else $error("host sync lost flag not cleared by read");

  AST_STATUS_SYNC: assert property (
    r.link == S_PREAMBLE && byte_done && !frame_err &&
    rx_byte == STATUS_BYTE |=> r.link == S_RX_SYNC)
    else $error("status byte did not mark receive sync");

  AST_AUTO_POLL: assert property (
    r.link == S_RX_SYNC && r.auto_poll && !loss_evt
    |=> r.link == S_POLL && ser_byte == POLL_BYTE)
    else $error("poll command not sent after sync");

  AST_NO_POLL: assert property (
    r.link == S_RX_SYNC && !r.auto_poll && !loss_evt
    |=> r.link == S_RUN)
    else $error("poll not suppressed");

  AST_LEVEL_BLOCK: assert property (
    r.line_mode && r.lde && !r.lps |=> r.line_mode)
    else $error("left line power with level detect on");

  AST_LINE_MODE: assert property (
    r.lps |=> r.line_mode)
    else $error("line power select ignored");

  AST_WATCHDOG: assert property (
    !r.ntr_off && !rx_edge && r.ntr_cnt == 17'(NTR_LIMIT - 1)
    |=> failsafe_trip)
    else $error("no-transition timer did not trip");

  // One frame slot is 81 cycles, so a strobe is never further away
  AST_STROBE: assert property (
    !is_sync(r.link) && !r.line_side_sync_lost |-> ##[0:81] tx_ready_strobe)
    else $error("transmit strobe stopped after loss");

endmodule : ibsc_top
`default_nettype wire

// [verif/ibsc_line_model.sv]
// Line-side partner: locks on host preamble, then sends framed bytes.
// Assumes the bench picks each byte and any stop-bit fault.
`timescale 1ns/100ps
`default_nettype none
module ibsc_line_model
  import ibsc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       barrier_tx,
  input  wire logic       en,
  input  wire logic [7:0] byte_in,
  input  wire logic       bad_stop,
  output logic            frame_start,
  output logic            barrier_rx
);
  // ************
  // Lock and framing
  // ************
  logic [4:0]  lock_cnt;
  logic        tx_q;
  logic [6:0]  cyc;
  logic [14:0] sh;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lock_cnt    <= 5'h00;
      tx_q        <= 1'b0;
      cyc         <= 7'h00;
      sh          <= 15'h0000;
      frame_start <= 1'b0;
      barrier_rx  <= 1'b0;
    end else begin
      tx_q        <= barrier_tx;
      frame_start <= 1'b0;
      if (barrier_tx && !tx_q && !lock_cnt[4]) begin
        lock_cnt <= lock_cnt + 5'h01;
      end
      if (cyc != 7'h00) begin
        cyc <= cyc - 7'h01;
        if (cyc[2:0] == 3'h0) begin
          barrier_rx <= sh[14];
          sh         <= {sh[13:0], 1'b0};
        end
      end else if (en && lock_cnt[4]) begin
        // Start bit, data MSB first, stop, six idle bits
        cyc         <= 7'h7f;
        sh          <= {byte_in, bad_stop, 6'h00};
        barrier_rx  <= 1'b1;
        frame_start <= 1'b1;
      end else begin
        // Pulled low while idle, so no stale level lingers
        barrier_rx <= 1'b0;
      end
    end
  end
endmodule : ibsc_line_model
`default_nettype wire

// [verif/ibsc_top_test.sv]
// Bench for the barrier sync controller: registers, power, sync, loss.
// Assumes the line-side model as far side and a short silence limit.
`timescale 1ns/100ps
`default_nettype none
module ibsc_top_test
  import ibsc_pkg::*;
;
  // ************
  // Signals
  // ************
  localparam int         NTR    = 200;
  localparam logic [3:0] REV_ID = 4'h9;  // Arbitrary revision value
  logic          clock = 1'b0;
  logic          arst_n = 1'b0;
  ibsc_avs_req_s req;
  ibsc_avs_rsp_s rsp;
  logic          irq, barrier_tx, barrier_rx, strobe, rx_valid;
  logic          failsafe_trip, line_power_mode, frame_start;
  logic [7:0]    tx_word, rx_word, adc_p, adc_n, byte_in;
  logic          en, bad_stop, chk_rx;
  logic [7:0]    q[$];
  logic [31:0]   seed = 32'h000034d3;
  logic [31:0]   tx_seed = 32'h000034d3;
  int            error_cnt = 0;
  int            n_tests = 0;

  always #2.5 clock = ~clock;

  ibsc_top #(.NTR_LIMIT(NTR)) i_ibsc_top (
    .clock(clock), .arst_n(arst_n), .avs_req(req), .avs_rsp(rsp),
    .irq(irq), .barrier_tx(barrier_tx), .barrier_rx(barrier_rx),
    .tx_word(tx_word), .tx_ready_strobe(strobe), .rx_word(rx_word),
    .rx_valid(rx_valid), .failsafe_trip(failsafe_trip),
    .line_power_mode(line_power_mode), .aux_adc_pos_input(adc_p),
    .aux_adc_neg_input(adc_n));
  ibsc_line_model i_ibsc_line_model (
    .clock(clock), .arst_n(arst_n), .barrier_tx(barrier_tx), .en(en),
    .byte_in(byte_in), .bad_stop(bad_stop), .frame_start(frame_start),
    .barrier_rx(barrier_rx));

  // ************
  // Helpers
  // ************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic [7:0] rnd8();
    seed = xs(seed);
    return seed[7:0];
  endfunction : rnd8

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Sampled on the falling edge so design updates have landed
  task automatic wait_for(ref logic s, input int lim, output logic got);
    got = 1'b0;
    for (int i = 0; i < lim && !got; i++) begin
      @(negedge clock);
      got = (s === 1'b1);
    end
  endtask : wait_for

  task automatic bus(input logic rd, input logic [7:0] a,
                     input logic [7:0] wd, output logic [7:0] rv);
    int n;
    n = 0;
    @(posedge clock);
    req.read       <= rd;
    req.write      <= !rd;
    req.address    <= a;
    req.writedata  <= {24'h000000, wd};
    req.byteenable <= 4'hf;
    // Waitrequest and data are taken at the accepting rising edge
    do begin
      @(posedge clock);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 20);
    check("waitrequest", rsp.waitrequest, 1'b0);
    rv = rsp.readdata[7:0];
    req.read  <= 1'b0;
    req.write <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    bus(1'b1, a, 8'h00, v);
    check($sformatf("reg %h", a), v, exp);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    bus(1'b0, a, d, v);
  endtask : wr

  // High cycles in one 81-cycle slot: 40 power at barrier power, 4 start bit, plus 4 per data one
  task automatic window(input int exp);
    int   ones;
    logic got;
    ones = 0;
    wait_for(strobe, 200, got);
    for (int i = 0; i < 81; i++) begin
      ones += int'(barrier_tx === 1'b1);
      @(negedge clock);
    end
    check("ones per slot", 32'(ones), 32'(exp));
    check("slot spacing", strobe, 1'b1);
  endtask : window

  task automatic next_frame(input logic [7:0] b);
    logic got;
    wait_for(frame_start, 300, got);
    check("frame start", got, 1'b1);
    @(posedge clock);
    byte_in <= b;
  endtask : next_frame

  task automatic lose_sync(input logic exp_irq);
    logic got;
    @(posedge clock);
    bad_stop <= 1'b1;
    next_frame(8'h00);
    en       <= 1'b0;
    bad_stop <= 1'b0;
    chk_rx   <= 1'b0;
    wait_for(irq, 300, got);
    check("irq", got, exp_irq);
    check("rx bytes left", 32'(q.size()), 32'h0);
    rd(8'h74, 8'h00);
    rd(8'h34, 8'h40);
    rd(8'h0c, 8'h02);
    @(negedge clock);
    check("irq", irq, 1'b0);
    rd(8'h0c, 8'h00);
  endtask : lose_sync

  // ************
  // Scenarios
  // ************
  always @(posedge clock) begin
    tx_seed <= xs(tx_seed);
    tx_word <= tx_seed[15:8];
  end

  always @(negedge clock) begin
    if (chk_rx && rx_valid === 1'b1) begin
      if (q.size() == 0)
        check("rx_valid", 1'b1, 1'b0);
      else
        check("rx_word", rx_word, q.pop_front());
    end
  end

  initial begin
    logic [7:0] d, nd, a, b;
    logic       got;
    req = '0;
    {en, bad_stop, chk_rx} = 3'b000;
    {byte_in, adc_p, adc_n} = 24'h000000;
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    rd(8'h34, 8'h40);
    rd(8'h34, 8'h00);
    rd(8'h08, 8'h00);
    rd(8'h0c, 8'h00);
    rd(8'h14, 8'h0a);
    rd(8'h54, 8'h00);
    rd(8'h74, 8'h00);
    rd(8'h78, 8'h00);
    rd(8'h40, 8'h00);
    wait_for(failsafe_trip, NTR + 50, got);
    check("failsafe_trip", got, 1'b1);
    rd(8'h34, 8'h40);
    wr(8'h54, 8'h40);
    wait_for(failsafe_trip, NTR + 50, got);
    check("failsafe_trip", got, 1'b0);
    wr(8'h54, 8'h00);
    window(60);
    wr(8'h08, 8'h04);
    repeat (100) @(posedge clock);
    check("line_power_mode", line_power_mode, 1'b1);
    window(20);
    wr(8'h08, 8'h08);
    repeat (100) @(posedge clock);
    check("line_power_mode", line_power_mode, 1'b1);
    wr(8'h08, 8'h00);
    repeat (100) @(posedge clock);
    check("line_power_mode", line_power_mode, 1'b0);
    a = rnd8();
    b = rnd8();
    @(posedge clock);
    adc_p <= a;
    adc_n <= b;
    rd(8'h80, a - b);
    @(posedge clock);
    en      <= 1'b1;
    byte_in <= STATUS_BYTE;
    chk_rx  <= 1'b1;
    d = rnd8();
    next_frame({4'h0, REV_ID});
    next_frame(d);
    for (int k = 0; k < 4; k++) begin
      nd = rnd8();
      next_frame(nd);
      q.push_back(d);
      d = nd;
    end
    rd(8'h74, {REV_ID, 4'h0});
    wr(8'h74, 8'hff);
    rd(8'h74, {REV_ID, 4'h0});
    bus(1'b1, 8'h34, 8'h00, nd);
    rd(8'h34, 8'h00);
    lose_sync(1'b1);
    wait_for(strobe, 200, got);
    check("strobe after loss", got, 1'b1);
    repeat (100) @(posedge clock);
    window(60);
    wr(8'h14, 8'h00);
    rd(8'h14, 8'h00);
    @(posedge clock);
    en      <= 1'b1;
    byte_in <= STATUS_BYTE;
    repeat (3) next_frame(8'h3c);
    rd(8'h74, 8'h00);
    lose_sync(1'b0);
    wr(8'h14, 8'h0a);
    complete_run();
  end

  initial begin
    repeat (30000) @(posedge clock);
    error_cnt++;
    $display("watchdog expired after 30000 cycles");
    complete_run();
  end
endmodule : ibsc_top_test
`default_nettype wire
